/* common/mscr_regs.svh */
// Purpose: Offsets, field positions, reset values and code limits for start-up configuration
// Assumes: Registers are 32-bit words on a plain strobe port
// Notes: Offsets are register indexes as printed; no byte addressing
`ifndef MSCR_REGS_SVH
`define MSCR_REGS_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define MSCR_ADDR_W 8
`define MSCR_OFF_CFG_A 8'h85
`define MSCR_OFF_CFG_B 8'h86
`define MSCR_OFF_STATUS 8'h87

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MSCR_RST_CFG_A 32'h00000000
`define MSCR_RST_CFG_B 32'h00000000

// ----------------------------------------
// Config A fields
// ----------------------------------------
`define MSCR_A_REPEAT_HI 5
`define MSCR_A_REPEAT_LO 4
`define MSCR_A_RSVD 3
`define MSCR_A_RAMP 2
`define MSCR_A_BRAKE 1
`define MSCR_A_REVSEL 0
`define MSCR_A_WMASK 32'h00000037

// ----------------------------------------
// Config B fields
// ----------------------------------------
`define MSCR_B_PARITY 31
`define MSCR_B_ILIM_HI 30
`define MSCR_B_ILIM_LO 27
`define MSCR_B_ACC1_HI 26
`define MSCR_B_ACC1_LO 23
`define MSCR_B_ACC2_HI 22
`define MSCR_B_ACC2_LO 19
`define MSCR_B_AUTO 18
`define MSCR_B_THR_HI 17
`define MSCR_B_THR_LO 13
`define MSCR_B_WMASK 32'hFFFFE000

// ----------------------------------------
// Code limits
// ----------------------------------------
`define MSCR_ILIM_MAX_CODE 4'hD

`endif

/* common/mscr_pkg.sv */
// Purpose: Types for the start-up configuration block
// Assumes: Used with mscr_regs.svh
// Notes: Physical units are scaled integers
package mscr_pkg;
   typedef logic [7:0] mscr_addr_t;
   typedef logic [31:0] mscr_word_t;
   // Current in mA, accel in tenth-Hz/s, threshold in tenth-percent
   typedef logic [11:0] mscr_milliamp_t;
   typedef logic [16:0] mscr_accel_t;
   typedef logic [9:0] mscr_permille_t;
   typedef enum logic [1:0] {
      MSCR_DIR_FWD = 2'h1,
      MSCR_DIR_REV = 2'h2
   } mscr_dir_t;
endpackage

/* verilog/mscr_startup_cfg.sv */
// Purpose: Start-up configuration registers with decoded settings for the drive logic
// Assumes: One clock, synchronous reset, plain strobe register port
// Notes: Reverse-drive settings are supplied by a neighbouring block through inputs
//
// Contract
// - Position detect runs once more than the two-bit repeat field value.
// - Ramp-down bit set ramps torque reference down at loop handoff.
// - Active braking only permitted while brake enable bit is set.
// - In reverse drive, select bit picks forward or reverse current and accel.
// - Second config register at offset 86h, resets to zero.
// - Current cap 0h=0.078A to Dh=3.75A; Eh and Fh invalid.
// - Linear accel selects sixteen rates, 0.1 to 10000 Hz/s.
// - Quadratic accel selects sixteen values, 0.0 to 10000 Hz/s2.
// - Auto handoff bit set: own decision; clear: use speed threshold.
// - Handoff threshold 1% at 0h up to 50% at 1Fh of full speed.
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`include "mscr_regs.svh"

module mscr_startup_cfg (
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire mscr_pkg::mscr_addr_t ADDR_I,
   input wire mscr_pkg::mscr_word_t WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output mscr_pkg::mscr_word_t RDATA_O,
   input wire logic REV_DRIVE_I,
   input wire logic [3:0] REV_ILIM_CODE_I,
   input wire logic [3:0] REV_ACC1_CODE_I,
   input wire logic [3:0] REV_ACC2_CODE_I,
   input wire logic IPD_DONE_I,
   input wire logic BRAKE_REQ_I,
   output logic [2:0] IPD_RUNS_O,
   output logic IPD_MORE_O,
   output logic RAMPDOWN_EN_O,
   output logic BRAKE_ALLOW_O,
   output mscr_pkg::mscr_dir_t PROFILE_O,
   output mscr_pkg::mscr_milliamp_t OL_ILIM_MA_O,
   output logic OL_ILIM_BAD_O,
   output mscr_pkg::mscr_accel_t OL_ACC1_O,
   output mscr_pkg::mscr_accel_t OL_ACC2_O,
   output logic AUTO_HANDOFF_O,
   output mscr_pkg::mscr_permille_t HANDOFF_THR_O
);
   import mscr_pkg::*;

   // ----------------------------------------
   // Code tables
   // ----------------------------------------
   function automatic mscr_milliamp_t ilim_ma(input logic [3:0] c);
      case (c)
         4'h0: ilim_ma = 12'd78;
         4'h1: ilim_ma = 12'd156;
         4'h2: ilim_ma = 12'd312;
         4'h3: ilim_ma = 12'd625;
         4'h4: ilim_ma = 12'd937;
         4'h5: ilim_ma = 12'd1250;
         4'h6: ilim_ma = 12'd1562;
         4'h7: ilim_ma = 12'd1875;
         4'h8: ilim_ma = 12'd2187;
         4'h9: ilim_ma = 12'd2500;
         4'hA: ilim_ma = 12'd2812;
         4'hB: ilim_ma = 12'd3125;
         4'hC: ilim_ma = 12'd3437;
         4'hD: ilim_ma = 12'd3750;
         // Invalid codes clamp to the lowest cap for safety
         default: ilim_ma = 12'd78;
      endcase
   endfunction

   // Tenths of Hz/s; shared by both accel fields except code 0
   function automatic mscr_accel_t accel(input logic [3:0] c, input logic quad);
      case (c)
         4'h0: accel = quad ? 17'd0 : 17'd1;
         4'h1: accel = 17'd5;
         4'h2: accel = 17'd10;
         4'h3: accel = 17'd25;
         4'h4: accel = 17'd50;
         4'h5: accel = 17'd100;
         4'h6: accel = 17'd250;
         4'h7: accel = 17'd500;
         4'h8: accel = 17'd750;
         4'h9: accel = 17'd1000;
         4'hA: accel = 17'd2500;
         4'hB: accel = 17'd5000;
         4'hC: accel = 17'd7500;
         4'hD: accel = 17'd10000;
         4'hE: accel = 17'd50000;
         default: accel = 17'd100000;
      endcase
   endfunction

   // Tenths of percent: 1% steps to 20%, then 2.5% steps
   function automatic mscr_permille_t thr_pm(input logic [4:0] c);
      if (c <= 5'h13) begin
         thr_pm = 10'(10 * (32'(c) + 1));
      end else begin
         thr_pm = 10'(200 + 25 * (32'(c) - 19));
      end
   endfunction

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   mscr_word_t cfg_a_r;
   mscr_word_t cfg_b_r;
   logic [2:0] ipd_count_r;

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         cfg_a_r <= `MSCR_RST_CFG_A;
      end else if (WR_I && ADDR_I == `MSCR_OFF_CFG_A) begin
         cfg_a_r <= WDATA_I & `MSCR_A_WMASK;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         cfg_b_r <= `MSCR_RST_CFG_B;
      end else if (WR_I && ADDR_I == `MSCR_OFF_CFG_B) begin
         cfg_b_r <= WDATA_I & `MSCR_B_WMASK;
      end
   end

   // ----------------------------------------
   // Position detect run counter
   // ----------------------------------------
   logic [2:0] ipd_runs;
   assign ipd_runs = {1'b0, cfg_a_r[`MSCR_A_REPEAT_HI:`MSCR_A_REPEAT_LO]} + 3'h1;

   // Counts completed runs; restarts when the repeat field is rewritten
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         ipd_count_r <= 3'h0;
      end else if (WR_I && ADDR_I == `MSCR_OFF_CFG_A) begin
         ipd_count_r <= 3'h0;
      end else if (IPD_DONE_I && ipd_count_r < ipd_runs) begin
         ipd_count_r <= ipd_count_r + 3'h1;
      end
   end

   // ----------------------------------------
   // Decoded settings
   // ----------------------------------------
   logic use_rev;
   logic [3:0] ilim_code;
   logic [3:0] acc1_code;
   logic [3:0] acc2_code;

   assign use_rev = REV_DRIVE_I && cfg_a_r[`MSCR_A_REVSEL];
   assign ilim_code = use_rev ? REV_ILIM_CODE_I : cfg_b_r[`MSCR_B_ILIM_HI:`MSCR_B_ILIM_LO];
   assign acc1_code = use_rev ? REV_ACC1_CODE_I : cfg_b_r[`MSCR_B_ACC1_HI:`MSCR_B_ACC1_LO];
   assign acc2_code = use_rev ? REV_ACC2_CODE_I : cfg_b_r[`MSCR_B_ACC2_HI:`MSCR_B_ACC2_LO];

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         IPD_RUNS_O <= 3'h1;
         IPD_MORE_O <= 1'b0;
      end else begin
         IPD_RUNS_O <= ipd_runs;
         IPD_MORE_O <= (ipd_count_r < ipd_runs) && !(IPD_DONE_I && ipd_count_r + 3'h1 >= ipd_runs);
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         RAMPDOWN_EN_O <= 1'b0;
         BRAKE_ALLOW_O <= 1'b0;
         AUTO_HANDOFF_O <= 1'b0;
      end else begin
         RAMPDOWN_EN_O <= cfg_a_r[`MSCR_A_RAMP];
         BRAKE_ALLOW_O <= cfg_a_r[`MSCR_A_BRAKE] && BRAKE_REQ_I;
         AUTO_HANDOFF_O <= cfg_b_r[`MSCR_B_AUTO];
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         PROFILE_O <= MSCR_DIR_FWD;
         OL_ILIM_MA_O <= 12'd78;
         OL_ILIM_BAD_O <= 1'b0;
         OL_ACC1_O <= 17'd1;
         OL_ACC2_O <= 17'd0;
      end else begin
         PROFILE_O <= use_rev ? MSCR_DIR_REV : MSCR_DIR_FWD;
         OL_ILIM_MA_O <= ilim_ma(ilim_code);
         OL_ILIM_BAD_O <= ilim_code > `MSCR_ILIM_MAX_CODE;
         OL_ACC1_O <= accel(acc1_code, 1'b0);
         OL_ACC2_O <= accel(acc2_code, 1'b1);
      end
   end

   // Threshold is zero while auto handoff owns the decision
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         HANDOFF_THR_O <= 10'd10;
      end else if (cfg_b_r[`MSCR_B_AUTO]) begin
         HANDOFF_THR_O <= 10'd0;
      end else begin
         HANDOFF_THR_O <= thr_pm(cfg_b_r[`MSCR_B_THR_HI:`MSCR_B_THR_LO]);
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         RDATA_O <= 32'h00000000;
      end else if (RD_I) begin
         case (ADDR_I)
            `MSCR_OFF_CFG_A: RDATA_O <= cfg_a_r;
            `MSCR_OFF_CFG_B: RDATA_O <= cfg_b_r;
            `MSCR_OFF_STATUS: RDATA_O <= {25'h0, ilim_code > `MSCR_ILIM_MAX_CODE, use_rev, 2'h0, ipd_count_r};
            default: RDATA_O <= 32'h00000000;
         endcase
      end else begin
         RDATA_O <= 32'h00000000;
      end
   end
endmodule

/* tb/mscr_startup_cfg_checker.sv */
// Purpose: Port assertions for start-up config registers
// Assumes: Bound to mscr_startup_cfg
// Notes: Decoded outputs lag a write by two edges
`timescale 1ns/10ps
`include "mscr_regs.svh"
module mscr_startup_cfg_checker (
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire mscr_pkg::mscr_addr_t ADDR_I,
   input wire mscr_pkg::mscr_word_t WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire mscr_pkg::mscr_word_t RDATA_O,
   input wire logic REV_DRIVE_I,
   input wire logic BRAKE_REQ_I,
   input wire logic [2:0] IPD_RUNS_O,
   input wire logic RAMPDOWN_EN_O,
   input wire logic BRAKE_ALLOW_O,
   input wire mscr_pkg::mscr_dir_t PROFILE_O,
   input wire mscr_pkg::mscr_milliamp_t OL_ILIM_MA_O,
   input wire logic OL_ILIM_BAD_O,
   input wire logic AUTO_HANDOFF_O,
   input wire mscr_pkg::mscr_permille_t HANDOFF_THR_O
);
   import mscr_pkg::*;
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   // A lone write, so the two-edge lag is unambiguous
   wire wa = WR_I && ADDR_I == `MSCR_OFF_CFG_A;
   wire wb = WR_I && ADDR_I == `MSCR_OFF_CFG_B;
   a_cfgb_readback: assert property (wb ##1 (RD_I && ADDR_I == `MSCR_OFF_CFG_B) |=>
      RDATA_O == ($past(WDATA_I, 2) & `MSCR_B_WMASK)) else $error("cfg_b readback wrong");
   a_rsvd_zero: assert property (RD_I && ADDR_I == `MSCR_OFF_CFG_A |=>
      RDATA_O[31:6] == 26'h0 && !RDATA_O[3]) else $error("cfg_a unused bits set");
   a_repeat_count: assert property (wa ##1 !wa |=>
      IPD_RUNS_O == {1'b0, $past(WDATA_I[5:4], 2)} + 3'h1) else $error("run count wrong");
   a_ramp_follow: assert property (wa ##1 !wa |=>
      RAMPDOWN_EN_O == $past(WDATA_I[2], 2)) else $error("ramp enable wrong");
   a_brake_gate: assert property (BRAKE_ALLOW_O |-> $past(BRAKE_REQ_I)) else $error("brake unrequested");
   a_brake_off: assert property (wa && !WDATA_I[1] ##1 !wa |=> !BRAKE_ALLOW_O) else $error("brake not off");
   a_fwd_profile: assert property (!$past(REV_DRIVE_I) |-> PROFILE_O == MSCR_DIR_FWD) else $error("profile");
   a_ilim_clamp: assert property (OL_ILIM_BAD_O |-> OL_ILIM_MA_O == 12'h04E) else $error("bad cap code");
   a_auto_thr: assert property (AUTO_HANDOFF_O |-> HANDOFF_THR_O == 10'h000) else $error("threshold used");
   c_readback: cover property (wb ##1 RD_I);
   c_brake: cover property (BRAKE_ALLOW_O);
   c_bad_cap: cover property (OL_ILIM_BAD_O);
endmodule
bind mscr_startup_cfg mscr_startup_cfg_checker i_mscr_startup_cfg_checker (.CORE_CLK_I, .RST_I, .ADDR_I,
   .WDATA_I, .WR_I, .RD_I, .RDATA_O, .REV_DRIVE_I, .BRAKE_REQ_I, .IPD_RUNS_O, .RAMPDOWN_EN_O,
   .BRAKE_ALLOW_O, .PROFILE_O, .OL_ILIM_MA_O, .OL_ILIM_BAD_O, .AUTO_HANDOFF_O, .HANDOFF_THR_O);

/* tb/mscr_startup_cfg_tb_top.sv */
// Purpose: Directed bench for start-up config registers
// Assumes: Strobe bus, read data one cycle after strobe
// Notes: Expected values follow the field code tables
`timescale 1ns/10ps
`include "mscr_regs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
   $display("Error t=%0t got %h exp %h", $time, g, e); end end
module mscr_startup_cfg_tb_top;
   import mscr_pkg::*;
   int failures = 0;
   int n_compared = 0;
   logic CORE_CLK_I = 0, RST_I = 1, WR_I = 0, RD_I = 0, REV_DRIVE_I = 0, IPD_DONE_I = 0, BRAKE_REQ_I = 0;
   mscr_addr_t ADDR_I = '0;
   mscr_word_t WDATA_I = '0, RDATA_O;
   logic [3:0] REV_ILIM_CODE_I = 4'h0, REV_ACC1_CODE_I = 4'h0, REV_ACC2_CODE_I = 4'h0;
   logic [2:0] IPD_RUNS_O;
   logic IPD_MORE_O, RAMPDOWN_EN_O, BRAKE_ALLOW_O, OL_ILIM_BAD_O, AUTO_HANDOFF_O;
   mscr_dir_t PROFILE_O;
   mscr_milliamp_t OL_ILIM_MA_O;
   mscr_accel_t OL_ACC1_O, OL_ACC2_O;
   mscr_permille_t HANDOFF_THR_O;
   mscr_startup_cfg i_mscr_startup_cfg (.CORE_CLK_I, .RST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
      .REV_DRIVE_I, .REV_ILIM_CODE_I, .REV_ACC1_CODE_I, .REV_ACC2_CODE_I, .IPD_DONE_I, .BRAKE_REQ_I,
      .IPD_RUNS_O, .IPD_MORE_O, .RAMPDOWN_EN_O, .BRAKE_ALLOW_O, .PROFILE_O, .OL_ILIM_MA_O, .OL_ILIM_BAD_O,
      .OL_ACC1_O, .OL_ACC2_O, .AUTO_HANDOFF_O, .HANDOFF_THR_O);
   initial begin
      forever #2 CORE_CLK_I = ~CORE_CLK_I;
   end
   // Strobe stays up until the next access, so accesses run back to back
   task automatic wr(input mscr_addr_t a, input mscr_word_t d);
      @(posedge CORE_CLK_I);
      WR_I <= 1'b1;
      RD_I <= 1'b0;
      ADDR_I <= a;
      WDATA_I <= d;
   endtask
   task automatic rd(input mscr_addr_t a, input mscr_word_t e);
      @(posedge CORE_CLK_I);
      RD_I <= 1'b1;
      WR_I <= 1'b0;
      ADDR_I <= a;
      @(posedge CORE_CLK_I);
      RD_I <= 1'b0;
      #1;
      `CHK(RDATA_O, e)
   endtask
   task automatic cfgb(input logic p, au, input logic [3:0] il, a1, a2, input logic [4:0] th,
      input mscr_milliamp_t ma, input logic bad, input mscr_accel_t e1, e2, input mscr_permille_t et);
      mscr_word_t w;
      w = {p, il, a1, a2, au, th, 13'h0000};
      wr(`MSCR_OFF_CFG_B, w);
      rd(`MSCR_OFF_CFG_B, w);
      `CHK(OL_ILIM_MA_O, ma)
      `CHK(OL_ILIM_BAD_O, bad)
      `CHK(OL_ACC1_O, e1)
      `CHK(OL_ACC2_O, e2)
      `CHK(AUTO_HANDOFF_O, au)
      `CHK(HANDOFF_THR_O, et)
   endtask
   task automatic stop_test();
      $display("Compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #10000;
      failures++;
      stop_test();
   end
   initial begin
      repeat (5) @(posedge CORE_CLK_I);
      RST_I <= 1'b0;
      rd(`MSCR_OFF_CFG_B, 32'h00000000);
      rd(`MSCR_OFF_CFG_A, 32'h00000000);
      `CHK(IPD_RUNS_O, 3'h1)
      `CHK(OL_ILIM_MA_O, 12'h04E)
      `CHK(HANDOFF_THR_O, 10'h00A)
      cfgb(1'b1, 1'b0, 4'hD, 4'hF, 4'hF, 5'h1F, 12'hEA6, 1'b0, 17'h186A0, 17'h186A0, 10'h1F4);
      cfgb(1'b0, 1'b0, 4'hE, 4'h0, 4'h0, 5'h00, 12'h04E, 1'b1, 17'h00001, 17'h00000, 10'h00A);
      cfgb(1'b0, 1'b1, 4'h0, 4'h0, 4'h0, 5'h1F, 12'h04E, 1'b0, 17'h00001, 17'h00000, 10'h000);
      @(posedge CORE_CLK_I);
      REV_DRIVE_I <= 1'b1;
      BRAKE_REQ_I <= 1'b1;
      REV_ILIM_CODE_I <= 4'hD;
      REV_ACC1_CODE_I <= 4'hF;
      REV_ACC2_CODE_I <= 4'hE;
      for (int f = 0; f < 4; f++) begin
         wr(`MSCR_OFF_CFG_A, {26'h3FFFFFF, f[1:0], 4'hF});
         rd(`MSCR_OFF_CFG_A, {26'h0, f[1:0], 4'h7});
         `CHK(IPD_RUNS_O, 3'(f + 1))
         `CHK(IPD_MORE_O, 1'b1)
         `CHK(RAMPDOWN_EN_O, 1'b1)
         `CHK(BRAKE_ALLOW_O, 1'b1)
         `CHK(PROFILE_O, MSCR_DIR_REV)
         `CHK(OL_ILIM_MA_O, 12'hEA6)
         `CHK(OL_ACC1_O, 17'h186A0)
         `CHK(OL_ACC2_O, 17'h0C350)
         repeat (f + 1) begin
            @(posedge CORE_CLK_I);
            IPD_DONE_I <= 1'b1;
         end
         @(posedge CORE_CLK_I);
         IPD_DONE_I <= 1'b0;
         @(posedge CORE_CLK_I);
         #1;
         `CHK(IPD_MORE_O, 1'b0)
         rd(`MSCR_OFF_STATUS, {25'h0, 1'b0, 1'b1, 2'h0, 3'(f + 1)});
      end
      wr(`MSCR_OFF_CFG_A, 32'h00000000);
      rd(`MSCR_OFF_CFG_A, 32'h00000000);
      `CHK(RAMPDOWN_EN_O, 1'b0)
      `CHK(BRAKE_ALLOW_O, 1'b0)
      `CHK(PROFILE_O, MSCR_DIR_FWD)
      `CHK(OL_ILIM_MA_O, 12'h04E)
      `CHK(OL_ACC1_O, 17'h00001)
      `CHK(OL_ACC2_O, 17'h00000)
      wr(8'h40, 32'hFFFFFFFF);
      rd(8'h40, 32'h00000000);
      stop_test();
   end
endmodule
